// *** sccp_pkg.sv ***
// package: register map, field layout, reset values and timing for the clock prescaler block
package sccp_pkg;

   // ****************************************
   // register map (word addresses, byte addr = 4 * index)
   // ****************************************
   localparam logic [1:0] SCCP_ADDR_TRIM    = 2'h0;
   localparam logic [1:0] SCCP_ADDR_DIVIDE  = 2'h1;
   localparam logic [1:0] SCCP_ADDR_FUSES   = 2'h2;
   localparam logic [1:0] SCCP_ADDR_STATUS  = 2'h3;

   // ****************************************
   // divide control fields
   // ****************************************
   localparam int         SCCP_UNLOCK_BIT   = 7;
   localparam logic [3:0] SCCP_DIV_RESET    = 4'h0;
   localparam logic [3:0] SCCP_DIV_RESET_D8 = 4'h3;
   localparam logic [3:0] SCCP_DIV_MAX      = 4'h8;
   localparam logic [2:0] SCCP_UNLOCK_CYC   = 3'h4;

   // ****************************************
   // fuse codes (0 = programmed)
   // ****************************************
   localparam logic [1:0] SCCP_SRC_EXT      = 2'h0;
   localparam logic [1:0] SCCP_SUT_NONE     = 2'h0;
   localparam logic [1:0] SCCP_SUT_SHORT    = 2'h1;
   localparam logic [1:0] SCCP_SUT_LONG     = 2'h2;

   // ****************************************
   // start-up timing
   // ****************************************
   localparam int SCCP_PD_CK          = 6;
   localparam int SCCP_RST_CK         = 14;
   localparam int SCCP_WDT_SHORT_CYC  = 4096;
   localparam int SCCP_WDT_LONG_CYC   = 8192;
   localparam logic [7:0] SCCP_TRIM_DEFAULT = 8'h80;

   typedef enum logic [1:0] {
      SCCP_ST_TIMEOUT = 2'b00,
      SCCP_ST_CLOCKS  = 2'b01,
      SCCP_ST_RUN     = 2'b10
   } sccp_state_t;

endpackage

// *** sccp_divider.sv ***
// synchronous counter prescaler with glitch-free ratio switch, clocked from the source clock
`timescale 1ns/1ps
module sccp_divider (
   // clock and reset
   input  wire logic       mclk_in,
   input  wire logic       rst_in,
   // control
   input  wire logic [3:0] div_sel_in,
   input  wire logic       load_in,
   // divided clock enable and level
   output logic            tick_out,
   output logic            clk_level_out
);
   import sccp_pkg::*;

   logic [8:0] cnt_reg;
   logic [3:0] cur_reg;
   logic [3:0] pend_reg;
   logic       pend_vld_reg;
   logic       tick_reg;
   logic       lvl_reg;
   logic       period_end;
   logic [8:0] limit;

   // limit of current period, in source cycles minus one
   always_comb begin
      limit = 9'(({8'h00, 1'b1} << cur_reg) - 9'h001);
   end
   assign period_end = (cnt_reg == limit);

   // ****************************************
   // counter and ratio switch
   // ****************************************
   // switch only at a period end, so no period is shorter than old or new
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_reg      <= 9'h000;
         cur_reg      <= 4'h0;
         pend_reg     <= 4'h0;
         pend_vld_reg <= 1'b0;
      end else begin
         if (load_in) begin
            pend_reg     <= div_sel_in;
            pend_vld_reg <= 1'b1;
         end
         if (period_end) begin
            cnt_reg <= 9'h000;
            // old period finishes, then new ratio runs
            if (pend_vld_reg && !load_in) begin
               cur_reg      <= pend_reg;
               pend_vld_reg <= 1'b0;
            end
         end else begin
            cnt_reg <= 9'(cnt_reg + 9'h001);
         end
      end
   end

   // divided clock: high in first half of each period above factor 1, toggling every cycle at factor 1
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         tick_reg <= 1'b0;
         lvl_reg  <= 1'b0;
      end else begin
         tick_reg <= period_end;
         lvl_reg  <= (cur_reg == 4'h0) ? ~lvl_reg : (cnt_reg <= (limit >> 1));
      end
   end

   assign tick_out      = tick_reg;
   assign clk_level_out = lvl_reg;
endmodule

// *** sccp_top.sv ***
// top: external clock, start-up delay, clock output, prescaler control, trim register
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - fuse 00 selects external clock input
// - startup fuse sets reset delay; power-down delay is a fixed 6 clocks
// - clock output fuse drives clock on pin
// - clock output pin carries divided clock, toggling each source cycle at factor 1
// - prescaler divides all clock domains together
// - ratio change never shortens any period
// - new ratio active after old plus new
// - unlock set only with other bits zero
// - unlock clears after four cycles or write
// - bits six to four read zero
// - division field gives two power code
// - reset division depends on divide-eight fuse
// - any division value accepted via unlock
// - trim loads factory value at reset
// - trim bits monotonic low to high
// - prescaler counter hidden from software
// - reset delay counted in watchdog cycles
module sccp_top #(
   parameter int WDT_SHORT_CYC = 4096,
   parameter int WDT_LONG_CYC  = 8192,
   parameter logic [7:0] FACTORY_TRIM = 8'h80
) (
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   // avalon-mm slave
   input  wire logic [1:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   // fuses (0 = programmed), wake and watchdog timing
   input  wire logic [1:0]  clock_source_select_fuse_in,
   input  wire logic [1:0]  startup_time_fuse_in,
   input  wire logic        clock_output_fuse_in,
   input  wire logic        divide_by_eight_fuse_in,
   input  wire logic        wdt_tick_in,
   input  wire logic        wake_in,
   // clock output pin and port data
   input  wire logic        port_data_in,
   input  wire logic        port_drive_in,
   output logic             clock_output_pin_out,
   output logic             clock_output_pin_oe_n_out,
   // system clock enable, core reset and oscillator trim
   output logic             sys_clk_en_out,
   output logic             core_reset_out,
   output logic [7:0]       oscillator_trim_out
);
   import sccp_pkg::*;

   logic [7:0]  trim_reg;
   logic [3:0]  div_reg;
   logic        unlock_reg;
   logic [2:0]  unlock_cnt_reg;
   logic [31:0] rdata_reg;
   logic        wait_reg;
   logic        fuse_cap_reg;
   logic        d8_reg;
   logic        clock_output_fuse_reg;
   logic        ext_ok_reg;
   logic [1:0]  sut_reg;
   sccp_state_t state_reg;
   logic [13:0] wdt_cnt_reg;
   logic [4:0]  ck_cnt_reg;
   logic        pin_reg;
   logic        pin_oe_n_reg;
   logic        en_reg;
   logic        core_rst_reg;
   logic        div_tick;
   logic        div_level;
   logic        load_div;
   logic        acc_wr;
   logic        acc_rd;
   logic        wr_div;
   logic        ck_target_hit;
   logic [13:0] wdt_target;
   logic [3:0]  div_sel;

   // ****************************************
   // fuse capture after reset release
   // ****************************************
   // fuses are straps: caught by a clocked step, never by the reset itself
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         fuse_cap_reg <= 1'b0;
         d8_reg       <= 1'b0;
         clock_output_fuse_reg    <= 1'b0;
         ext_ok_reg   <= 1'b0;
         sut_reg      <= 2'h0;
      end else if (!fuse_cap_reg) begin
         fuse_cap_reg <= 1'b1;
         d8_reg       <= ~divide_by_eight_fuse_in;
         clock_output_fuse_reg    <= ~clock_output_fuse_in;
         ext_ok_reg   <= (clock_source_select_fuse_in == SCCP_SRC_EXT);
         sut_reg      <= startup_time_fuse_in;
      end
   end

   // ****************************************
   // start-up sequencing
   // ****************************************
   always_comb begin
      case (sut_reg)
         // delay target in watchdog ticks: count only when wdt_tick_in is high
         SCCP_SUT_SHORT: wdt_target = 14'(WDT_SHORT_CYC);
         SCCP_SUT_LONG:  wdt_target = 14'(WDT_LONG_CYC);
         default:        wdt_target = 14'h0000;
      endcase
   end
   // 14 clocks after reset, 6 after wake from power-down
   assign ck_target_hit = (ck_cnt_reg == 5'(SCCP_RST_CK - 1));

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg    <= SCCP_ST_TIMEOUT;
         wdt_cnt_reg  <= 14'h0000;
         ck_cnt_reg   <= 5'h00;
         core_rst_reg <= 1'b1;
      end else begin
         case (state_reg)
            SCCP_ST_TIMEOUT: begin
               // timeout counted in watchdog ticks; reserved codes hold reset
               if (fuse_cap_reg && ext_ok_reg && sut_reg != 2'h3) begin
                  if (sut_reg == SCCP_SUT_NONE || wdt_cnt_reg == wdt_target) begin
                     state_reg <= SCCP_ST_CLOCKS;
                  end else if (wdt_tick_in) begin
                     wdt_cnt_reg <= 14'(wdt_cnt_reg + 14'h0001);
                  end
               end
            end
            SCCP_ST_CLOCKS: begin
               if (ck_target_hit) begin
                  state_reg    <= SCCP_ST_RUN;
                  core_rst_reg <= 1'b0;
                  ck_cnt_reg   <= 5'h00;
               end else begin
                  ck_cnt_reg <= 5'(ck_cnt_reg + 5'h01);
               end
            end
            SCCP_ST_RUN: begin
               if (wake_in) begin
                  // power-down wake: only the short clock delay applies
                  ck_cnt_reg   <= 5'(SCCP_RST_CK - SCCP_PD_CK);
                  state_reg    <= SCCP_ST_CLOCKS;
                  core_rst_reg <= 1'b1;
               end
            end
            default: state_reg <= SCCP_ST_TIMEOUT;
         endcase
      end
   end

   // ****************************************
   // avalon-mm slave: one wait cycle per access
   // ****************************************
   // writes act only at the edge where waitrequest is seen low
   assign acc_wr = avs_write_in && !wait_reg && avs_byteenable_in[0];
   assign acc_rd = avs_read_in && wait_reg;
   assign wr_div = acc_wr && (avs_address_in == SCCP_ADDR_DIVIDE);

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         wait_reg <= 1'b1;
      end else begin
         wait_reg <= !(wait_reg && (avs_read_in || avs_write_in));
      end
   end

   // ****************************************
   // divide control with timed unlock
   // ****************************************
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         unlock_reg     <= 1'b0;
         unlock_cnt_reg <= 3'h0;
      end else begin
         if (wr_div && unlock_reg && !avs_writedata_in[SCCP_UNLOCK_BIT]) begin
            unlock_reg <= 1'b0; // division write ends the window
         end else if (unlock_reg) begin
            // rewrite neither extends nor clears the window
            if (unlock_cnt_reg == SCCP_UNLOCK_CYC - 3'h1) begin
               unlock_reg <= 1'b0;
            end
            unlock_cnt_reg <= 3'(unlock_cnt_reg + 3'h1);
         end else if (wr_div && avs_writedata_in[7:0] == 8'h80) begin
            unlock_reg     <= 1'b1; // only with all other bits zero
            unlock_cnt_reg <= 3'h0;
         end
      end
   end

   assign load_div = wr_div && unlock_reg && !avs_writedata_in[SCCP_UNLOCK_BIT];

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         div_reg <= SCCP_DIV_RESET;
      end else if (fuse_cap_reg == 1'b0) begin
         div_reg <= divide_by_eight_fuse_in ? SCCP_DIV_RESET : SCCP_DIV_RESET_D8;
      end else if (load_div) begin
         div_reg <= avs_writedata_in[3:0]; // any code stored regardless of fuse
      end
   end

   // ****************************************
   // oscillator trim
   // ****************************************
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         trim_reg <= SCCP_TRIM_DEFAULT;
      end else if (fuse_cap_reg == 1'b0) begin
         trim_reg <= FACTORY_TRIM; // factory value reloaded on reset
      end else if (acc_wr && avs_address_in == SCCP_ADDR_TRIM) begin
         trim_reg <= avs_writedata_in[7:0]; // all eight bits used, monotonic
      end
   end

   // read mux; counter state not visible
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_reg <= 32'h0000_0000;
      end else if (acc_rd) begin
         case (avs_address_in)
            SCCP_ADDR_TRIM:   rdata_reg <= {24'h000000, trim_reg};
            SCCP_ADDR_DIVIDE: rdata_reg <= {24'h000000, unlock_reg, 3'h0, div_reg};
            SCCP_ADDR_FUSES:  rdata_reg <= {24'h000000, 1'b0, d8_reg, clock_output_fuse_reg, ext_ok_reg,
                                            sut_reg, clock_source_select_fuse_in};
            SCCP_ADDR_STATUS: rdata_reg <= {28'h0000000, core_rst_reg, 1'b0, state_reg};
            default:          rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // prescaler and clock output
   // ****************************************
   // divider takes the value being stored, not the old register contents
   always_comb begin
      if (!fuse_cap_reg) begin
         div_sel = divide_by_eight_fuse_in ? SCCP_DIV_RESET : SCCP_DIV_RESET_D8;
      end else if (load_div) begin
         div_sel = avs_writedata_in[3:0];
      end else begin
         div_sel = div_reg;
      end
      // reserved codes clamp to the largest factor
      if (div_sel > SCCP_DIV_MAX) begin
         div_sel = SCCP_DIV_MAX;
      end
   end

   sccp_divider u_div (
      .mclk_in       (mclk_in),
      .rst_in        (rst_in),
      .div_sel_in    (div_sel),
      .load_in       (load_div || !fuse_cap_reg),
      .tick_out      (div_tick),
      .clk_level_out (div_level)
   );

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         en_reg       <= 1'b0;
         pin_reg      <= 1'b0;
         pin_oe_n_reg <= 1'b1;
      end else begin
         en_reg <= div_tick; // one enable for cpu, io, adc and flash
         if (clock_output_fuse_reg) begin
            pin_reg      <= div_level; // divided clock, also in reset
            pin_oe_n_reg <= 1'b0;
         end else begin
            pin_reg      <= port_data_in; // normal port function
            pin_oe_n_reg <= ~port_drive_in;
         end
      end
   end

   assign avs_readdata_out          = rdata_reg;
   assign avs_waitrequest_out       = wait_reg;
   assign sys_clk_en_out            = en_reg;
   assign core_reset_out            = core_rst_reg;
   assign clock_output_pin_out      = pin_reg;
   assign clock_output_pin_oe_n_out = pin_oe_n_reg;
   assign oscillator_trim_out       = trim_reg;
endmodule

// *** sccp_top_assertions.sv ***
// checker: concurrent properties on the prescaler top ports
`timescale 1ns/1ps
module sccp_top_assertions
   import sccp_pkg::*;
#(
   parameter logic [7:0] FACTORY_TRIM = 8'h80
) (
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   // bus
   input  wire logic [1:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   input  wire logic [31:0] avs_readdata_out,
   input  wire logic        avs_waitrequest_out,
   // fuses and port
   input  wire logic [1:0]  clock_source_select_fuse_in,
   input  wire logic [1:0]  startup_time_fuse_in,
   input  wire logic        clock_output_fuse_in,
   input  wire logic        port_data_in,
   input  wire logic        port_drive_in,
   // outputs
   input  wire logic        clock_output_pin_out,
   input  wire logic        clock_output_pin_oe_n_out,
   input  wire logic        sys_clk_en_out,
   input  wire logic        core_reset_out,
   input  wire logic [7:0]  oscillator_trim_out
);
   // ****************************************
   // helper counters
   // ****************************************
   logic [1:0] up_reg;
   logic [8:0] gap_reg;
   logic       up;
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) up_reg <= 2'h0;
      else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
   end
   // fuses are captured at the first edge, so judge pins from the third on
   assign up = up_reg[1];
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) gap_reg <= 9'h000;
      else if (sys_clk_en_out || core_reset_out) gap_reg <= 9'h000;
      else if (gap_reg != 9'h1FF) gap_reg <= gap_reg + 9'h001;
   end
   // ****************************************
   // properties
   // ****************************************
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   property p_trim_reset;
      $fell(rst_in) |=> oscillator_trim_out == FACTORY_TRIM;
   endproperty
   a_trim_reset: assert property (p_trim_reset)
      else $error("trim not reloaded after reset");
   property p_trim_write;
      avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
         && avs_address_in == SCCP_ADDR_TRIM |=> oscillator_trim_out == $past(avs_writedata_in[7:0]);
   endproperty
   a_trim_write: assert property (p_trim_write)
      else $error("trim write not applied");
   property p_div_rsvd;
      !avs_waitrequest_out && $past(avs_read_in && avs_address_in == SCCP_ADDR_DIVIDE)
         |-> avs_readdata_out[6:4] == 3'h0;
   endproperty
   a_div_rsvd: assert property (p_div_rsvd)
      else $error("reserved divide bits not zero");
   property p_upper;
      !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0;
   endproperty
   a_upper: assert property (p_upper)
      else $error("upper read bits not zero");
   property p_out_on;
      up && !clock_output_fuse_in |-> !clock_output_pin_oe_n_out;
   endproperty
   a_out_on: assert property (p_out_on)
      else $error("clock pin not driven");
   property p_port;
      up && clock_output_fuse_in |=> clock_output_pin_oe_n_out == !$past(port_drive_in)
         && (!$past(port_drive_in) || clock_output_pin_out == $past(port_data_in));
   endproperty
   a_port: assert property (p_port)
      else $error("pin not under port control");
   property p_short_start;
      $fell(rst_in) && clock_source_select_fuse_in == SCCP_SRC_EXT
         && startup_time_fuse_in == SCCP_SUT_NONE |-> core_reset_out[*8] ##[5:10] !core_reset_out;
   endproperty
   a_short_start: assert property (p_short_start)
      else $error("short start-up length wrong");
   property p_hold;
      up && clock_source_select_fuse_in != SCCP_SRC_EXT |-> core_reset_out;
   endproperty
   a_hold: assert property (p_hold)
      else $error("core ran on non-external source");
   property p_gap;
      gap_reg <= 9'h0FF;
   endproperty
   a_gap: assert property (p_gap)
      else $error("divided period above 256");
   c_unlock: cover property (!avs_waitrequest_out && avs_readdata_out[7]);
   c_start: cover property ($fell(core_reset_out));
   c_slow: cover property (sys_clk_en_out && gap_reg == 9'h0FF);
endmodule
bind sccp_top sccp_top_assertions #(.FACTORY_TRIM(FACTORY_TRIM)) u_sccp_chk (
   .mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .clock_source_select_fuse_in(clock_source_select_fuse_in),
   .startup_time_fuse_in(startup_time_fuse_in), .clock_output_fuse_in(clock_output_fuse_in),
   .port_data_in(port_data_in), .port_drive_in(port_drive_in),
   .clock_output_pin_out(clock_output_pin_out),
   .clock_output_pin_oe_n_out(clock_output_pin_oe_n_out),
   .sys_clk_en_out(sys_clk_en_out), .core_reset_out(core_reset_out),
   .oscillator_trim_out(oscillator_trim_out));

// *** sccp_clk_partner.sv ***
// partner: watchdog oscillator stand-in and a load timing the clock pin
`timescale 1ns/1ps
module sccp_clk_partner (
   // clock and reset
   input  wire logic       mclk_in,
   input  wire logic       rst_in,
   // clock pin as the load sees it
   input  wire logic       pin_in,
   input  wire logic       pin_oe_n_in,
   // watchdog tick and measured pin period
   output logic            wdt_tick_out,
   output logic [9:0]      period_out
);
   logic [1:0] div_reg;
   logic [9:0] cnt_reg;
   logic       last_reg;
   // watchdog oscillator runs free at a quarter of the source rate
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) div_reg <= 2'h0;
      else div_reg <= div_reg + 2'h1;
   end
   assign wdt_tick_out = (div_reg == 2'h3);
   // only a driven pin is timed; rising edge to rising edge
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_reg    <= 10'h000;
         last_reg   <= 1'b0;
         period_out <= 10'h000;
      end else begin
         last_reg <= pin_in;
         if (!pin_oe_n_in && pin_in && !last_reg) begin
            period_out <= cnt_reg + 10'h001;
            cnt_reg    <= 10'h000;
         end else cnt_reg <= cnt_reg + 10'h001;
      end
   end
endmodule

// *** system_clock_prescaler_control_bench.sv ***
// bench: fuse resets, register traffic, prescaler changes, port stimulus
`timescale 1ns/1ps
module system_clock_prescaler_control_bench;
   import sccp_pkg::*;
   localparam int WS = 8;
   localparam int WL = 16;
   // arbitrary factory trim for the run
   localparam logic [7:0] FT = 8'h5A;
   logic        mclk_in = 1'b0, rst_in = 1'b1, rd = 1'b0, wr = 1'b0;
   logic [1:0]  addr = 2'h0, cks = 2'h0, startup_time_fuse = 2'h0;
   logic [31:0] wd = 32'h0, q, lf = 32'hD9F0E444, pl = 32'hD9F0E444;
   logic [3:0]  be = 4'h0, c, cur;
   logic        ckf = 1'b0, d8f = 1'b0, pdat = 1'b0, pdrv = 1'b0, wake = 1'b0;
   logic [7:0]  v;
   logic [5:0]  cfg [5] = '{6'h07, 6'h09, 6'h0E, 6'h23, 6'h00};
   wire  [31:0] rdat;
   wire  [9:0]  per;
   wire  [7:0]  trim;
   wire         wreq, pin, oen, en, crst, tick;
   int          n_fail = 0, comparisons = 0, cyc = 0, g [3], ex, mn, n;
   sccp_top #(.WDT_SHORT_CYC(WS), .WDT_LONG_CYC(WL), .FACTORY_TRIM(FT)) i_sccp_top (
      .mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(addr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
      .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
      .clock_source_select_fuse_in(cks), .startup_time_fuse_in(startup_time_fuse),
      .clock_output_fuse_in(ckf), .divide_by_eight_fuse_in(d8f), .wdt_tick_in(tick),
      .wake_in(wake), .port_data_in(pdat), .port_drive_in(pdrv),
      .clock_output_pin_out(pin), .clock_output_pin_oe_n_out(oen),
      .sys_clk_en_out(en), .core_reset_out(crst), .oscillator_trim_out(trim));
   sccp_clk_partner i_sccp_clk_partner (.mclk_in(mclk_in), .rst_in(rst_in), .pin_in(pin),
      .pin_oe_n_in(oen), .wdt_tick_out(tick), .period_out(per));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // lower edge of the start-up window, 300 meaning never released
   function automatic int slo(input logic [5:0] k);
      if (k[5:4] != SCCP_SRC_EXT || k[3:2] == 2'h3) return 300;
      return 13 + (k[3:2] == SCCP_SUT_SHORT ? 4 * WS - 4 : k[3:2] == SCCP_SUT_LONG ? 4 * WL - 4 : 0);
   endfunction
   // fixed source rate: never steps by more than 2 percent
   always #5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      cyc  <= cyc + 1;
      pl   <= lfsr(pl);
      pdat <= pl[0];
      pdrv <= pl[5];
      if (cyc == 20000) begin
         n_fail++;
         $display("ERROR %0t timeout", $time);
         end_sim();
      end
   end
   task end_sim;
      $display("fails %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task bus(input logic r, input logic [1:0] a, input logic [7:0] d, input logic [3:0] b);
      @(posedge mclk_in);
      addr <= a;
      wd   <= {24'h0, d};
      be   <= b;
      rd   <= r;
      wr   <= !r;
      @(posedge mclk_in);
      while (wreq !== 1'b0) @(posedge mclk_in);
      q  = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // three enable-to-enable gaps from the next pulse on
   task gaps;
      do @(posedge mclk_in); while (en !== 1'b1);
      for (int j = 0; j < 3; j++) begin
         g[j] = 0;
         do begin @(posedge mclk_in); g[j]++; end while (en !== 1'b1);
      end
   endtask
   initial begin
      foreach (cfg[k]) begin
         rst_in <= 1'b1;
         {cks, startup_time_fuse, ckf, d8f} <= cfg[k];
         repeat (16) @(posedge mclk_in);
         rst_in <= 1'b0;
         n = 0;
         while (crst !== 1'b0 && n < 300) begin @(posedge mclk_in); n++; end
         chk(n >= slo(cfg[k]) && n <= slo(cfg[k]) + 12, 1);
         bus(1, SCCP_ADDR_DIVIDE, 8'h00, 4'hF);
         chk(q, cfg[k][0] ? SCCP_DIV_RESET : SCCP_DIV_RESET_D8);
         bus(1, SCCP_ADDR_FUSES, 8'h00, 4'hF);
         chk(q, {25'h0, !cfg[k][0], !cfg[k][1], cfg[k][5:4] == 2'h0, cfg[k][3:2], cfg[k][5:4]});
         bus(1, SCCP_ADDR_TRIM, 8'h00, 4'hF);
         chk(q, FT);
      end
      cur = SCCP_DIV_RESET_D8;
      for (int i = 0; i < 10; i++) begin
         lf = lfsr(lf);
         c  = (i < 9) ? i[3:0] : 4'h9 + {1'b0, lf[2:0] % 3'h7};
         ex = (c > SCCP_DIV_MAX) ? 256 : 1 << c;
         mn = (cur > SCCP_DIV_MAX) ? 256 : 1 << cur;
         mn = (ex < mn) ? ex : mn;
         bus(0, SCCP_ADDR_DIVIDE, 8'h80, 4'hF);
         bus(0, SCCP_ADDR_DIVIDE, {4'h0, c}, 4'hF);
         gaps();
         chk(g[0] >= mn && g[1] >= mn, 1);
         chk(g[2], ex);
         if (c > 0) chk(per, ex);
         bus(1, SCCP_ADDR_DIVIDE, 8'h00, 4'hF);
         chk(q, {28'h0, c});
         cur = c;
      end
      bus(0, SCCP_ADDR_DIVIDE, 8'h81, 4'hF);
      bus(0, SCCP_ADDR_DIVIDE, 8'h05, 4'hF);
      bus(1, SCCP_ADDR_DIVIDE, 8'h00, 4'hF);
      chk(q, {28'h0, cur});
      bus(0, SCCP_ADDR_DIVIDE, 8'h80, 4'hF);
      bus(1, SCCP_ADDR_DIVIDE, 8'h00, 4'hF);
      chk(q, {24'h0, 4'h8, cur});
      repeat (8) @(posedge mclk_in);
      bus(0, SCCP_ADDR_DIVIDE, 8'h02, 4'hF);
      bus(1, SCCP_ADDR_DIVIDE, 8'h00, 4'hF);
      chk(q, {28'h0, cur});
      bus(0, SCCP_ADDR_DIVIDE, 8'h80, 4'hF);
      bus(0, SCCP_ADDR_DIVIDE, 8'h80, 4'hF);
      bus(0, SCCP_ADDR_DIVIDE, 8'h01, 4'hF);
      bus(1, SCCP_ADDR_DIVIDE, 8'h00, 4'hF);
      chk(q, {28'h0, cur});
      // no memory writes run here, so the full trim range is allowed
      for (int j = 0; j < 6; j++) begin
         lf = lfsr(lf);
         v  = (j == 0) ? 8'h00 : (j == 1) ? 8'hFF : lf[7:0];
         bus(0, SCCP_ADDR_TRIM, v, 4'hF);
         bus(0, SCCP_ADDR_TRIM, ~v, 4'h0);
         bus(1, SCCP_ADDR_TRIM, 8'h00, 4'hF);
         chk(q, {24'h0, v});
         chk(trim, v);
      end
      bus(0, SCCP_ADDR_FUSES, 8'hFF, 4'hF);
      bus(1, SCCP_ADDR_FUSES, 8'h00, 4'hF);
      chk(q, 32'h70);
      // power-down wake: core held for the short start-up only
      wake <= 1'b1;
      @(posedge mclk_in);
      wake <= 1'b0;
      n = 0;
      repeat (10) begin @(posedge mclk_in); n += (crst === 1'b1); end
      chk(n, SCCP_PD_CK);
      end_sim();
   end
endmodule
